// ===== src/pin_mux_pkg.sv
// Package: constants, modes and carriers for the mode-dependent pin multiplexer
`default_nettype none
package pin_mux_pkg;

    // Bus (E) cycle timing: four mclk per E cycle, one-cycle phase steps
    localparam logic [1:0] E_PHASE_AS = 2'h0;
    localparam logic [1:0] E_PHASE_CAPTURE = 2'h1;
    localparam logic [1:0] E_HIGH_FIRST = 2'h2;
    localparam logic [1:0] E_PHASE_LAST = 2'h3;
    localparam logic [2:0] STROBE_B_LEN = 3'h4;

    // Mode-select pin encodings, vector is {mode_select_b, mode_select_a}
    localparam logic [1:0] MODE_PINS_BOOT = 2'h0;
    localparam logic [1:0] MODE_PINS_TEST = 2'h1;
    localparam logic [1:0] MODE_PINS_SINGLE = 2'h2;
    localparam logic [1:0] MODE_PINS_EXPANDED = 2'h3;

    // Register byte offsets on the APB
    localparam logic [7:0] OFS_TIMER_PORT_DATA_REG = 8'h00;
    localparam logic [7:0] OFS_PULSE_ACCUM_CONTROL_REG = 8'h04;
    localparam logic [7:0] OFS_PORTB = 8'h08;
    localparam logic [7:0] OFS_PORTC = 8'h0C;
    localparam logic [7:0] OFS_PORTC_DIR = 8'h10;
    localparam logic [7:0] OFS_HSK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_PORTC_LATCH = 8'h1C;
    localparam logic [7:0] OFS_CAP_SEL = 8'h20;

    // Field positions
    localparam int PULSE_ACCUM_CONTROL_REG_DIR7 = 7;
    localparam int PULSE_ACCUM_CONTROL_REG_DIR3 = 3;
    localparam int PULSE_ACCUM_CONTROL_REG_CMP5 = 2;
    localparam int PULSE_ACCUM_CONTROL_REG_OC1_TRIG = 1;
    localparam int HSK_HANDSHAKE_STROBE_OUT_POL = 0;
    localparam int HSK_HANDSHAKE_STROBE_IN_RISE = 1;
    localparam int HSK_IRV = 2;
    localparam int STAT_EXP = 2;
    localparam int STAT_FLAG = 3;

    // Writable masks and reset values
    localparam logic [7:0] PULSE_ACCUM_CONTROL_REG_MASK = 8'h8E;
    localparam logic [7:0] TIMER_PORT_DATA_REG_LATCH_MASK = 8'hF8;
    localparam logic [7:0] HSK_MASK = 8'h07;
    localparam logic [7:0] CAP_SEL_MASK = 8'h70;
    localparam logic [7:0] RST_REG = 8'h00;

    // Width of the synchronised pin bundle: mode 2, strobe A 1, port C 8, port A 8
    localparam int SYNC_W = 19;

    typedef enum logic [1:0] {modeSingleChip, modeExpanded, modeTest, modeBootstrap} mode_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic internal;
        logic opcodeFetch;
        logic [15:0] addr;
        logic [7:0] data;
    } busReq_t;

    typedef struct packed {
        logic oc1Level;
        logic [4:0] oc1Mask;
        logic [3:0] ocLevel;
        logic [3:0] ocEnable;
    } timerOut_t;

    typedef struct packed {
        logic [2:0] captureUpper;
        logic [3:0] capture;
        logic pulseAccum;
    } timerIn_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apbReq_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apbRsp_t;

endpackage
`default_nettype wire

// ===== src/pin_sync.sv
// Two-flop synchroniser for every pin that the multiplexer samples
`default_nettype none
module pin_sync
    import pin_mux_pkg::*;
(
    input wire logic mclk,
    input wire logic [SYNC_W-1:0] pinIn,
    output var logic [SYNC_W-1:0] pinSync
);

    typedef struct packed {
        logic [SYNC_W-1:0] first;
        logic [SYNC_W-1:0] second;
    } syncState_t;

    syncState_t state_ff;
    syncState_t nxt_state;

    // No reset: mode pins must pass through while reset is held
    always_comb
    begin
        nxt_state.first = pinIn;
        nxt_state.second = state_ff.first;
    end

    always_ff @(posedge mclk)
    begin
        state_ff <= nxt_state;
    end

    assign pinSync = state_ff.second;

endmodule
`default_nettype wire

// ===== src/mode_pin_function_mux.sv
// Mode-dependent pin multiplexer for ports A, B, C and the strobe pins
`default_nettype none
module mode_pin_function_mux
    import pin_mux_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire apbReq_t apbReq,
    output var apbRsp_t apbRsp,
    input wire busReq_t busReq,
    output var logic busTaken,
    output var logic [7:0] busReadData,
    output var logic busReadValid,
    input wire timerOut_t timerOut,
    output var timerIn_t timerIn,
    input wire logic modeSelectA,
    input wire logic modeSelectB,
    output var logic instructionStartOut,
    output var logic instructionStartOeN,
    input wire logic handshakeStrobeIn,
    output var logic addressLatchStrobe,
    output var logic strobeAOeN,
    output var logic strobeBPinOut,
    output var logic strobeBPinOeN,
    output var logic eClock,
    output var logic [7:0] portBOut,
    input wire logic [7:0] portCIn,
    output var logic [7:0] portCOut,
    output var logic [7:0] portCOeN,
    input wire logic [7:0] portAIn,
    output var logic [7:0] portAOut,
    output var logic [7:0] portAOeN
);

    typedef struct packed {
        logic [1:0] phase;
        mode_t mode;
        busReq_t cur;
        logic prevRead;
        logic [7:0] readData;
        logic readValid;
        logic taken;
        logic [7:0] portAData;
        logic [7:0] pulse_accum_control_reg;
        logic [7:0] portBData;
        logic [7:0] portCData;
        logic [7:0] portCDir;
        logic [7:0] hsk;
        logic [7:0] capSel;
        logic [7:0] portCLatch;
        logic strobeAFlag;
        logic strobeAPrev;
        logic [2:0] strobeBCnt;
        apbRsp_t apb;
        logic isOut;
        logic isOeN;
        logic strobeAOut;
        logic strobeAOeN;
        logic strobeBOut;
        logic strobeBOeN;
        logic eClk;
        logic [7:0] portBOut;
        logic [7:0] portCOut;
        logic [7:0] portCOeN;
        logic [7:0] portAOut;
        logic [7:0] portAOeN;
        timerIn_t tmr;
    } state_t;

    state_t state_ff;
    state_t nxt_state;
    logic [SYNC_W-1:0] syn;
    logic [1:0] synMode;
    logic synStrA;
    logic [7:0] synPc;
    logic [7:0] synPa;
    logic expNow;
    logic apbAccess;
    logic strAEdge;
    logic [7:0] aIsOut;
    logic [7:0] aDrv;
    logic [7:0] aRead;
    logic [1:0] nPhase;
    logic cycleStart;
    logic irvRead;
    logic [7:0] rdByte;
    logic rdMapped;
    logic ic4Src;

    // Every pin input crosses two flops before any logic sees it
    pin_sync uSync (
        .mclk(mclk),
        .pinIn({modeSelectB, modeSelectA, handshakeStrobeIn, portCIn, portAIn}),
        .pinSync(syn)
    );

    assign synMode = syn[18:17];
    assign synStrA = syn[16];
    assign synPc = syn[15:8];
    assign synPa = syn[7:0];

    // Expanded and test share one pin assignment
    assign expNow = (state_ff.mode == modeExpanded) || (state_ff.mode == modeTest);
    assign apbAccess = apbReq.psel && apbReq.penable;
    assign strAEdge = state_ff.hsk[HSK_HANDSHAKE_STROBE_IN_RISE] ? (synStrA && !state_ff.strobeAPrev)
                                                  : (!synStrA && state_ff.strobeAPrev);

    // Port A per-bit direction and driver input; same in every mode
    for (genvar i = 0; i < 8; i++)
    begin : gPortA
        if (i == 7)
        begin : gBit7
            assign aIsOut[i] = state_ff.pulse_accum_control_reg[PULSE_ACCUM_CONTROL_REG_DIR7];
            assign aDrv[i] = timerOut.oc1Mask[4] ? timerOut.oc1Level : state_ff.portAData[i];
        end
        else if (i >= 4)
        begin : gBit64
            assign aIsOut[i] = !state_ff.capSel[i];
            assign aDrv[i] = timerOut.ocEnable[6-i] ? timerOut.ocLevel[6-i] :
                             (timerOut.oc1Mask[i-3] ? timerOut.oc1Level
                                                    : state_ff.portAData[i]);
        end
        else if (i == 3)
        begin : gBit3
            assign aIsOut[i] = state_ff.pulse_accum_control_reg[PULSE_ACCUM_CONTROL_REG_DIR3];
            assign aDrv[i] = (state_ff.pulse_accum_control_reg[PULSE_ACCUM_CONTROL_REG_CMP5] && timerOut.ocEnable[3]) ?
                             timerOut.ocLevel[3] :
                             (timerOut.oc1Mask[0] ? timerOut.oc1Level
                                                  : state_ff.portAData[i]);
        end
        else
        begin : gBit20
            assign aIsOut[i] = 1'b0;
            assign aDrv[i] = 1'b0;
        end
        assign aRead[i] = aIsOut[i] ? aDrv[i] : synPa[i];
    end

    // OC1 can stand in for the pin so its edges fire capture 4
    assign ic4Src = state_ff.pulse_accum_control_reg[PULSE_ACCUM_CONTROL_REG_OC1_TRIG] ? timerOut.oc1Level
                                                   : (!state_ff.pulse_accum_control_reg[PULSE_ACCUM_CONTROL_REG_CMP5] && synPa[3]);

    function automatic mode_t decodeMode(input logic [1:0] pins);
        mode_t m;
        case (pins)
            MODE_PINS_BOOT: m = modeBootstrap;
            MODE_PINS_TEST: m = modeTest;
            MODE_PINS_SINGLE: m = modeSingleChip;
            MODE_PINS_EXPANDED: m = modeExpanded;
            default: m = modeSingleChip;
        endcase
        return m;
    endfunction

    // Whole next state: bus phase, registers, then pins from the next phase
    always_comb
    begin
        nxt_state = state_ff;
        nPhase = state_ff.phase + 2'h1;
        cycleStart = (state_ff.phase == E_PHASE_LAST);
        irvRead = 1'b0;
        rdByte = 8'h00;
        rdMapped = 1'b1;
        case (apbReq.paddr)
            OFS_TIMER_PORT_DATA_REG: rdByte = aRead;
            OFS_PULSE_ACCUM_CONTROL_REG: rdByte = state_ff.pulse_accum_control_reg;
            OFS_PORTB: rdByte = state_ff.portBData;
            OFS_PORTC: rdByte = expNow ? state_ff.portCData :
                       ((state_ff.portCDir & state_ff.portCData) | (~state_ff.portCDir & synPc));
            OFS_PORTC_DIR: rdByte = state_ff.portCDir;
            OFS_HSK: rdByte = state_ff.hsk;
            OFS_STATUS: rdByte = {4'h0, state_ff.strobeAFlag, expNow, state_ff.mode};
            OFS_PORTC_LATCH: rdByte = state_ff.portCLatch;
            OFS_CAP_SEL: rdByte = state_ff.capSel;
            default: rdMapped = 1'b0;
        endcase
        if (srst)
        begin
            // Enabled pins released, port B and E driven low while reset holds; mode follows the pins each cycle
            nxt_state = '0;
            nxt_state.mode = decodeMode(synMode);
            nxt_state.phase = E_PHASE_LAST;
            nxt_state.pulse_accum_control_reg = RST_REG;
            nxt_state.isOeN = 1'b1;
            nxt_state.strobeAOeN = 1'b1;
            nxt_state.strobeBOeN = 1'b1;
            nxt_state.strobeBOut = 1'b1;
            nxt_state.portCOeN = 8'hFF;
            nxt_state.portAOeN = 8'hFF;
        end
        else
        begin
            nxt_state.taken = 1'b0;
            nxt_state.readValid = 1'b0;
            nxt_state.phase = nPhase;
            // Mode is never rewritten outside reset
            nxt_state.mode = state_ff.mode;
            if (cycleStart)
            begin
                nxt_state.cur = busReq.valid ? busReq : '0;
                nxt_state.taken = busReq.valid;
                nxt_state.prevRead = expNow && state_ff.cur.valid && !state_ff.cur.write
                                     && !state_ff.cur.internal;
            end
            // Read data leaves the synchroniser one clock after E falls
            if ((state_ff.phase == E_PHASE_CAPTURE) && state_ff.prevRead)
            begin
                nxt_state.readData = synPc;
                nxt_state.readValid = 1'b1;
                nxt_state.prevRead = 1'b0;
            end
            if (state_ff.strobeBCnt != 3'h0)
            begin
                nxt_state.strobeBCnt = state_ff.strobeBCnt - 3'h1;
            end
            // APB: one wait state, write lands on the pready edge
            nxt_state.apb.pready = 1'b0;
            nxt_state.apb.pslverr = 1'b0;
            if (apbAccess && !state_ff.apb.pready)
            begin
                nxt_state.apb.pready = 1'b1;
                nxt_state.apb.pslverr = !rdMapped;
                nxt_state.apb.prdata = {24'h00_0000, rdByte};
            end
            if (apbAccess && state_ff.apb.pready && apbReq.pwrite)
            begin
                case (apbReq.paddr)
                    OFS_TIMER_PORT_DATA_REG: nxt_state.portAData = apbReq.pwdata[7:0] & TIMER_PORT_DATA_REG_LATCH_MASK;
                    OFS_PULSE_ACCUM_CONTROL_REG: nxt_state.pulse_accum_control_reg = apbReq.pwdata[7:0] & PULSE_ACCUM_CONTROL_REG_MASK;
                    OFS_PORTB:
                    begin
                        nxt_state.portBData = apbReq.pwdata[7:0];
                        nxt_state.strobeBCnt = STROBE_B_LEN;
                    end
                    OFS_PORTC: nxt_state.portCData = apbReq.pwdata[7:0];
                    OFS_PORTC_DIR: nxt_state.portCDir = apbReq.pwdata[7:0];
                    OFS_HSK: nxt_state.hsk = apbReq.pwdata[7:0] & HSK_MASK;
                    OFS_STATUS:
                    begin
                        if (apbReq.pwdata[STAT_FLAG])
                        begin
                            nxt_state.strobeAFlag = 1'b0;
                        end
                    end
                    OFS_CAP_SEL: nxt_state.capSel = apbReq.pwdata[7:0] & CAP_SEL_MASK;
                    default: nxt_state.strobeAFlag = nxt_state.strobeAFlag;
                endcase
            end
            // Strobe A latch event comes after the clear so the set wins
            nxt_state.strobeAPrev = synStrA;
            if (!expNow && strAEdge)
            begin
                nxt_state.portCLatch = synPc;
                nxt_state.strobeAFlag = 1'b1;
            end
            // Pins, computed for the phase the next edge enters
            nxt_state.eClk = (nPhase >= E_HIGH_FIRST);
            nxt_state.isOut = 1'b0;
            nxt_state.isOeN = !(nxt_state.cur.valid && nxt_state.cur.opcodeFetch);
            if (expNow)
            begin
                irvRead = nxt_state.cur.valid && !nxt_state.cur.write
                          && nxt_state.cur.internal && state_ff.hsk[HSK_IRV];
                nxt_state.strobeAOut = (nPhase == E_PHASE_AS);
                nxt_state.strobeAOeN = 1'b0;
                nxt_state.portBOut = nxt_state.cur.addr[15:8];
                // Held from cycle start, so back-to-back writes never glitch high
                nxt_state.strobeBOut = !(nxt_state.cur.valid && nxt_state.cur.write);
                nxt_state.strobeBOeN = irvRead;
                if (nPhase < E_HIGH_FIRST)
                begin
                    nxt_state.portCOut = nxt_state.cur.addr[7:0];
                    nxt_state.portCOeN = 8'h00;
                end
                else if ((nxt_state.cur.valid && nxt_state.cur.write) || irvRead)
                begin
                    nxt_state.portCOut = nxt_state.cur.data;
                    nxt_state.portCOeN = 8'h00;
                end
                else
                begin
                    nxt_state.portCOut = 8'h00;
                    nxt_state.portCOeN = 8'hFF;
                end
            end
            else
            begin
                nxt_state.strobeAOut = 1'b0;
                nxt_state.strobeAOeN = 1'b1;
                nxt_state.portBOut = nxt_state.portBData;
                nxt_state.strobeBOut = (nxt_state.strobeBCnt != 3'h0) ?
                                       state_ff.hsk[HSK_HANDSHAKE_STROBE_OUT_POL] : !state_ff.hsk[HSK_HANDSHAKE_STROBE_OUT_POL];
                nxt_state.strobeBOeN = 1'b0;
                nxt_state.portCOut = nxt_state.portCData;
                nxt_state.portCOeN = ~nxt_state.portCDir;
            end
            // Port A ignores the mode entirely
            nxt_state.portAOut = aDrv;
            nxt_state.portAOeN = ~aIsOut;
            nxt_state.tmr.pulseAccum = synPa[7];
            nxt_state.tmr.capture = {ic4Src, synPa[0], synPa[1], synPa[2]};
            nxt_state.tmr.captureUpper = synPa[6:4] & state_ff.capSel[6:4];
        end
    end

    always_ff @(posedge mclk)
    begin
        state_ff <= nxt_state;
    end

    // Outputs straight from the state register
    assign apbRsp = state_ff.apb;
    assign busTaken = state_ff.taken;
    assign busReadData = state_ff.readData;
    assign busReadValid = state_ff.readValid;
    assign timerIn = state_ff.tmr;
    assign instructionStartOut = state_ff.isOut;
    assign instructionStartOeN = state_ff.isOeN;
    assign addressLatchStrobe = state_ff.strobeAOut;
    assign strobeAOeN = state_ff.strobeAOeN;
    assign strobeBPinOut = state_ff.strobeBOut;
    assign strobeBPinOeN = state_ff.strobeBOeN;
    assign eClock = state_ff.eClk;
    assign portBOut = state_ff.portBOut;
    assign portCOut = state_ff.portCOut;
    assign portCOeN = state_ff.portCOeN;
    assign portAOut = state_ff.portAOut;
    assign portAOeN = state_ff.portAOeN;

    // Checks on the mode and on the pins and timer inputs the block drives
    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (srst);

    modeHeld_a: assert property ($past(!srst) |-> $stable(state_ff.mode))
        else $error("mode changed outside reset");
    modeFromPins_a: assert property ($fell(srst)
        |-> state_ff.mode == decodeMode($past(synMode)))
        else $error("mode not taken from pins at reset release");
    startPulse_a: assert property ((cycleStart && busReq.valid && busReq.opcodeFetch)
        |=> (!instructionStartOeN && !instructionStartOut) [*4])
        else $error("instruction start not low for a full E cycle");
    strobeRole_a: assert property ($past(!srst) |-> (strobeAOeN == !expNow)
        && (!addressLatchStrobe || !eClock))
        else $error("strobe A role or timing wrong");
    writeLow_a: assert property ((cycleStart && busReq.valid && busReq.write && expNow)
        |=> (!strobeBPinOut && !strobeBPinOeN) [*4])
        else $error("read/write not low through write cycle");
    backToBack_a: assert property ($past(!srst) && expNow && state_ff.cur.write
        && $past(state_ff.cur.write) |-> $stable(strobeBPinOut))
        else $error("read/write glitched between writes");
    irvDrive_a: assert property ($past(!srst) && expNow && eClock && strobeBPinOeN
        |-> portCOeN == 8'h00 && portCOut == state_ff.cur.data)
        else $error("visible internal read not driven on port C");
    portBAddr_a: assert property ($past(!srst) && expNow
        |-> portBOut == state_ff.cur.addr[15:8])
        else $error("port B not carrying high address");
    portCAddr_a: assert property ($past(!srst) && expNow && !eClock
        |-> portCOeN == 8'h00 && portCOut == state_ff.cur.addr[7:0])
        else $error("port C not carrying low address");
    fixedInputs_a: assert property ($past(!srst) |-> portAOeN[2:0] == 3'h7
        && portAOeN[3] == !$past(state_ff.pulse_accum_control_reg[PULSE_ACCUM_CONTROL_REG_DIR3]))
        else $error("port A direction wrong");
    pulseFeed_a: assert property ($past(!srst) |-> timerIn.pulseAccum == $past(synPa[7]))
        else $error("pulse accumulator input not following bit 7");

    coverWrites_c: cover property (expNow && state_ff.cur.write ##4 state_ff.cur.write);
    coverIrv_c: cover property (expNow && strobeBPinOeN && eClock);
    coverStrobeA_c: cover property (!expNow && strAEdge);
    coverStart_c: cover property ($fell(instructionStartOeN));

endmodule
`default_nettype wire

// ===== test/bus_partner.sv
// External address latch and byte memory on the multiplexed bus
`default_nettype none
module bus_partner
(
    input wire logic mclk,
    input wire logic addrStrobe,
    input wire logic eClk,
    input wire logic rdWr,
    input wire logic [7:0] cOut,
    input wire logic [7:0] cOeN,
    output var logic [7:0] cIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] lowAddr;
    logic [7:0] lastC = 8'h00;
    logic [7:0] mem [256];
    // Transparent while strobe high, holds once it falls
    always_latch
        if (addrStrobe)
            lowAddr <= cOut;
    // Stores write data; remembers the wire for the floating pattern
    always @(posedge mclk)
    begin
        if (eClk && !rdWr)
            mem[lowAddr] <= cOut;
        lastC <= cIn;
    end
    // Device wins where enabled; memory answers reads; else an inverting pattern
    always_comb
        for (int i = 0; i < 8; i++)
            cIn[i] = !cOeN[i] ? cOut[i] : (eClk && rdWr) ? mem[lowAddr][i] : ~lastC[i];
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the mode-dependent pin multiplexer
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
`define WT(c) for (int k = 0; k < 300; k++) begin @(posedge mclk); if (c) break; \
    if (k == 299) begin n_fail++; conclude(); end end
module tb
    import pin_mux_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 0, srst = 1, modeSelectA = 1, modeSelectB = 1, handshakeStrobeIn = 0;
    apbReq_t apbReq = '0;
    apbRsp_t apbRsp;
    busReq_t busReq = '0;
    timerOut_t timerOut = '0;
    timerIn_t timerIn;
    logic busTaken, busReadValid, instructionStartOut, instructionStartOeN, eClock;
    logic addressLatchStrobe, strobeAOeN, strobeBPinOut, strobeBPinOeN;
    logic [7:0] busReadData, portBOut, portCIn, portCOut, portCOeN, portAIn, portAOut, portAOeN;
    logic [7:0] paExt = 8'h00;
    logic [31:0] rd;
    logic err;
    int n_fail = 0, num_checks = 0, rwHi = 0, c0;
    // Tri-state style wire: device drives where enabled, else the outside level
    assign portAIn = (portAOut & ~portAOeN) | (paExt & portAOeN);
    always #25 mclk = ~mclk;
    // Running count of cycles with read/write high
    always @(posedge mclk)
        rwHi <= rwHi + int'(strobeBPinOut);
    mode_pin_function_mux mode_pin_function_mux_inst (.mclk, .srst, .apbReq, .apbRsp, .busReq,
        .busTaken, .busReadData, .busReadValid, .timerOut, .timerIn, .modeSelectA, .modeSelectB,
        .instructionStartOut, .instructionStartOeN, .handshakeStrobeIn, .addressLatchStrobe,
        .strobeAOeN, .strobeBPinOut, .strobeBPinOeN, .eClock, .portBOut, .portCIn, .portCOut,
        .portCOeN, .portAIn, .portAOut, .portAOeN);
    bus_partner bus_partner_inst (.mclk(mclk), .addrStrobe(addressLatchStrobe), .eClk(eClock),
        .rdWr(strobeBPinOut), .cOut(portCOut), .cOeN(portCOeN), .cIn(portCIn));
    task automatic conclude();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Reset held six cycles with the mode pins set throughout
    task automatic rst(input logic b, input logic a);
        modeSelectB <= b;
        modeSelectA <= a;
        srst <= 1'b1;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
    endtask
    // APB transfer; leading edge keeps back-to-back calls from double assigning
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        apbReq <= '{1'b1, 1'b0, wr, a, {24'h00_0000, d}};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        `WT(apbRsp.pready)
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask
    // Bus request held until taken
    task automatic bus(input busReq_t r);
        @(posedge mclk);
        busReq <= r;
        `WT(busTaken)
        busReq <= '0;
    endtask
    // Expanded: status, writes back to back, read back, visibility, fetch
    task automatic expandedBus();
        apb(1'b0, OFS_STATUS, 8'h00);
        `CHK("mode", 3'h5, rd[2:0])
        `CHK("strobeA oe", 1'b0, strobeAOeN)
        bus('{1'b1, 1'b1, 1'b0, 1'b0, 16'h1234, 8'h5A});
        `CHK("portB addr", 8'h12, portBOut)
        c0 = rwHi;
        bus('{1'b1, 1'b1, 1'b0, 1'b0, 16'h1235, 8'hA7});
        `WT(eClock)
        `CHK("portC data", 8'hA7, portCOut)
        `CHK("rw low", c0, rwHi)
        bus('{1'b1, 1'b0, 1'b0, 1'b0, 16'h1234, 8'h00});
        `WT(eClock)
        `CHK("rw read", 1'b1, strobeBPinOut)
        `CHK("portC rel", 8'hFF, portCOeN)
        `WT(busReadValid)
        `CHK("read data", 8'h5A, busReadData)
        apb(1'b1, OFS_HSK, 8'h04);
        bus('{1'b1, 1'b0, 1'b1, 1'b0, 16'h0040, 8'hC3});
        `WT(eClock)
        `CHK("irv data", 8'hC3, portCOut)
        `CHK("rw float", 1'b1, strobeBPinOeN)
        bus('{1'b1, 1'b0, 1'b1, 1'b1, 16'h0041, 8'h00});
        `CHK("start low", 2'b00, {instructionStartOeN, instructionStartOut})
        repeat (8) @(posedge mclk);
        `CHK("start idle", 1'b1, instructionStartOeN)
    endtask
    // Port A directions, latch, timer ownership and readback
    task automatic timer_port_data_reg();
        apb(1'b1, OFS_PULSE_ACCUM_CONTROL_REG, 8'h88);
        apb(1'b1, OFS_TIMER_PORT_DATA_REG, 8'h88);
        paExt <= 8'h05;
        timerOut <= '{1'b0, 5'h00, 4'h1, 4'h1};
        repeat (4) @(posedge mclk);
        `CHK("pa7", 1'b1, portAOut[7])
        `CHK("pa3 oe", 1'b0, portAOeN[3])
        `CHK("pa6 cmp", 1'b1, portAOut[6])
        apb(1'b0, OFS_TIMER_PORT_DATA_REG, 8'h00);
        `CHK("timer_port_data_reg rd", 8'hCD, rd[7:0])
        `CHK("accum", 1'b1, timerIn.pulseAccum)
        `CHK("caps", 3'h5, timerIn.capture[2:0])
        apb(1'b0, 8'h24, 8'h00);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_PULSE_ACCUM_CONTROL_REG, 8'h8C);
        apb(1'b1, OFS_TIMER_PORT_DATA_REG, 8'h00);
        timerOut <= '{1'b0, 5'h00, 4'h9, 4'h9};
        repeat (4) @(posedge mclk);
        `CHK("pa6 kept", 1'b1, portAOut[6])
        `CHK("pa7 clr", 1'b0, portAOut[7])
        `CHK("cmp5", 1'b1, portAOut[3])
        // Compare 1 feeds capture 4; upper pins turned into capture inputs
        apb(1'b1, OFS_PULSE_ACCUM_CONTROL_REG, 8'h8E);
        apb(1'b1, OFS_CAP_SEL, 8'h70);
        paExt <= 8'h50;
        timerOut <= '{1'b1, 5'h00, 4'h9, 4'h9};
        repeat (6) @(posedge mclk);
        `CHK("ic4 oc1", 1'b1, timerIn.capture[3])
        `CHK("cap upper", 3'h5, timerIn.captureUpper)
    endtask
    // Single-chip after a second reset: port B is plain output
    task automatic singleChip();
        rst(1'b1, 1'b0);
        apb(1'b0, OFS_STATUS, 8'h00);
        `CHK("mode sc", 3'h0, rd[2:0])
        `CHK("strobeA in", 1'b1, strobeAOeN)
        `CHK("pa dir sc", 8'h8F, portAOeN)
        apb(1'b1, OFS_PORTB, 8'hA5);
        @(posedge mclk);
        `CHK("strobe pulse", 2'b00, {strobeBPinOeN, strobeBPinOut})
        bus('{1'b1, 1'b1, 1'b0, 1'b0, 16'hFF00, 8'h11});
        repeat (4) @(posedge mclk);
        `CHK("portB gp", 8'hA5, portBOut)
        `CHK("rw unused", 2'b01, {strobeBPinOeN, strobeBPinOut})
        // Falling edge on strobe A sets the flag; writing one clears it
        handshakeStrobeIn <= 1'b1;
        repeat (4) @(posedge mclk);
        handshakeStrobeIn <= 1'b0;
        repeat (4) @(posedge mclk);
        apb(1'b0, OFS_STATUS, 8'h00);
        `CHK("strobeA flag", 1'b1, rd[STAT_FLAG])
        apb(1'b1, OFS_STATUS, 8'h08);
        apb(1'b0, OFS_STATUS, 8'h00);
        `CHK("flag clear", 1'b0, rd[STAT_FLAG])
    endtask
    initial
    begin
        rst(1'b1, 1'b1);
        expandedBus();
        timer_port_data_reg();
        singleChip();
        conclude();
    end
endmodule
`default_nettype wire
